// ---- design/gpib_status_and_id_responder.sv ----
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Channel query answers type code, absent or invalid code, then serial number.
// R2: Name query answers the configured identity name as a string.
// R3: Identity query answers maker, model, serial, firmware major, minor, build.
// R4: Model field carries the option suffix only when the option is fitted.
// R5: Status commands are accepted only when they arrive over GPIB.
// R6: Wait-to-continue is valid and does nothing.
// R7: Event enable command loads the 0..255 argument into the event mask.
// R8: Status bit 5 is set while an enabled event bit is set.
// R9: Event mask query returns the mask unchanged.
// R10: Operation complete command sets event bit 0.
// R11: Service enable command loads 0..255 into the service request mask.
// R12: Service mask query returns the mask.
// R13: Status bit 0 is set while an enabled measurement flag is set.
// R14: Status bit 4 is set while a response waits to be read.
// R15: Status bit 6 is the master summary of enabled status bits.
// R16: Status byte query returns the current status byte.
// R17: Self-test query always answers 0 and starts nothing.
// R18: Measurement mask command stores which flags may set status bit 0.
// R19: Measurement mask query returns the mask.
// R20: Event register query returns its value then clears it.
// R21: SRQ follows any status bit enabled in the service request mask.
module gpib_status_and_id_responder
    import gpib_resp_pkg::*;
#(
    parameter int unsigned NUM_CH = 4,
    parameter logic [DATA_W-1:0] FW_MAJOR = 32'h00000001,
    parameter logic [DATA_W-1:0] FW_MINOR = 32'h00000000,
    parameter logic [DATA_W-1:0] FW_BUILD = 32'h00000000
) (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic i_CMD_VALID,
    input wire cmd_s i_CMD,
    output logic o_CMD_READY,
    output logic o_CMD_REJECT,
    output logic o_RSP_VALID,
    output rsp_s o_RSP,
    input wire logic i_RSP_READY,
    input wire logic [15:0] i_MEAS_FLAGS,
    input wire chan_info_s [NUM_CH-1:0] i_CHAN_INFO,
    input wire logic i_OPTION_FITTED,
    input wire err_s i_PARSE_ERR,
    output logic [7:0] o_STATUS_BYTE,
    output logic o_SRQ
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [0:0] {
        S_IDLE = 1'b0,
        S_SEND = 1'b1
    } rsp_state_e;

    typedef struct packed {
        rsp_state_e st;
        logic [2:0] cnt;
        field_kind_e [NFIELD-1:0] kind;
        logic [NFIELD-1:0][DATA_W-1:0] data;
        logic reject;
        logic exec_err;
        logic ready;
        logic valid;
        logic last;
    } resp_s;

    localparam resp_s RESP_RST = '{S_IDLE, 3'h0, '0, '0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

    resp_s r_reg;
    resp_s r_next;

    stat_ctl_s ctl;
    err_s err_in;
    logic [7:0] esr_val;
    logic [7:0] ese_val;
    logic [7:0] sre_val;
    logic [15:0] mce_val;
    logic [7:0] stb_val;
    logic srq_val;

    // ----------------------------------------
    // Status registers
    // ----------------------------------------
    gpib_status_core u_core (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_ctl(ctl),
        .i_err(err_in),
        .i_rsp_avail(r_reg.st == S_SEND),
        .i_meas_flags(i_MEAS_FLAGS),
        .o_esr(esr_val),
        .o_ese(ese_val),
        .o_sre(sre_val),
        .o_mce(mce_val),
        .o_stb(stb_val),
        .o_srq(srq_val)
    );

    always_comb begin
        err_in = i_PARSE_ERR;
        err_in.exec = i_PARSE_ERR.exec | r_reg.exec_err;
    end

    // ----------------------------------------
    // Command decode and response shifter
    // ----------------------------------------
    always_comb begin
        logic take;
        logic status_cmd;
        chan_info_s ci;
        take = 1'b0;
        status_cmd = 1'b0;
        ci = '0;
        ctl = '0;
        ctl.arg = i_CMD.arg;
        r_next = r_reg;
        r_next.reject = 1'b0;
        r_next.exec_err = 1'b0;
        case (r_reg.st)
            S_IDLE: begin
                take = i_CMD_VALID;
            end
            S_SEND: begin
                if (i_RSP_READY) begin
                    r_next.cnt = r_reg.cnt - 3'h1;
                    for (int i = 0; i < NFIELD - 1; i++) begin
                        r_next.kind[i] = r_reg.kind[i+1];
                        r_next.data[i] = r_reg.data[i+1];
                    end
                    if (r_reg.cnt == 3'h1) begin
                        r_next.st = S_IDLE;
                    end
                end
            end
            default: begin
                r_next.st = S_IDLE;
            end
        endcase

        if (take) begin
            case (i_CMD.code)
                CMD_CHANNEL_INFO_QUERY_Q, CMD_NAME_Q, CMD_IDN_Q: status_cmd = 1'b0;
                default: status_cmd = 1'b1;
            endcase
            if (status_cmd && !i_CMD.gpib) begin
                r_next.reject = 1'b1; // R5
            end else begin
                r_next.kind = '{default: FK_INT};
                r_next.data = '0;
                case (i_CMD.code)
                    CMD_CHANNEL_INFO_QUERY_Q: begin
                        if (32'(i_CMD.chan) >= NUM_CH) begin
                            r_next.exec_err = 1'b1;
                        end else begin
                            ci = i_CHAN_INFO[i_CMD.chan];
                            r_next.kind[0] = FK_TYPE; // R1
                            if (!ci.fitted) begin
                                r_next.data[0] = {16'h0000, CHAN_ABSENT_CODE}; // R1
                            end else if (!ci.valid) begin
                                r_next.data[0] = {16'h0000, CHAN_INVALID_CODE}; // R1
                            end else begin
                                r_next.data[0] = {16'h0000, ci.type_code};
                            end
                            r_next.data[1] = ci.serial; // R1
                            r_next.cnt = 3'h2;
                            r_next.st = S_SEND;
                        end
                    end
                    CMD_NAME_Q: begin
                        r_next.kind[0] = FK_NAME; // R2
                        r_next.cnt = 3'h1;
                        r_next.st = S_SEND;
                    end
                    CMD_IDN_Q: begin
                        r_next.kind[0] = FK_MAKER; // R3
                        r_next.kind[1] = i_OPTION_FITTED ? FK_MODEL_OPT : FK_MODEL; // R4
                        r_next.kind[2] = FK_SERIAL;
                        r_next.data[3] = FW_MAJOR;
                        r_next.data[4] = FW_MINOR;
                        r_next.data[5] = FW_BUILD;
                        r_next.cnt = 3'h6; // R3
                        r_next.st = S_SEND;
                    end
                    CMD_WAIT: begin
                        r_next.st = S_IDLE; // R6
                    end
                    CMD_ESE: begin
                        ctl.ese_wr = 1'b1; // R7
                    end
                    CMD_ESE_Q: begin
                        r_next.data[0] = {24'h000000, ese_val}; // R9
                        r_next.cnt = 3'h1;
                        r_next.st = S_SEND;
                    end
                    CMD_OPC: begin
                        ctl.opc = 1'b1; // R10
                    end
                    CMD_SRE: begin
                        ctl.sre_wr = 1'b1; // R11
                    end
                    CMD_SRE_Q: begin
                        r_next.data[0] = {24'h000000, sre_val}; // R12
                        r_next.cnt = 3'h1;
                        r_next.st = S_SEND;
                    end
                    CMD_STB_Q: begin
                        r_next.data[0] = {24'h000000, stb_val}; // R16
                        r_next.cnt = 3'h1;
                        r_next.st = S_SEND;
                    end
                    CMD_TST_Q: begin
                        r_next.data[0] = TST_ANSWER; // R17
                        r_next.cnt = 3'h1;
                        r_next.st = S_SEND;
                    end
                    CMD_MCE: begin
                        ctl.mce_wr = 1'b1; // R18
                    end
                    CMD_MCE_Q: begin
                        r_next.data[0] = {16'h0000, mce_val}; // R19
                        r_next.cnt = 3'h1;
                        r_next.st = S_SEND;
                    end
                    CMD_ESR_Q: begin
                        r_next.data[0] = {24'h000000, esr_val}; // R20
                        ctl.esr_clr = 1'b1; // R20
                        r_next.cnt = 3'h1;
                        r_next.st = S_SEND;
                    end
                    default: begin
                        r_next.reject = 1'b1;
                    end
                endcase
            end
        end
        // Handshake flags registered so outputs come from flops
        r_next.ready = (r_next.st == S_IDLE);
        r_next.valid = (r_next.st == S_SEND);
        r_next.last = (r_next.cnt == 3'h1);
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            r_reg <= RESP_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_CMD_READY = r_reg.ready;
    assign o_CMD_REJECT = r_reg.reject;
    assign o_RSP_VALID = r_reg.valid;
    assign o_RSP = '{r_reg.kind[0], r_reg.data[0], r_reg.last};
    assign o_STATUS_BYTE = stb_val; // R16
    assign o_SRQ = srq_val; // R21

endmodule : gpib_status_and_id_responder
`default_nettype wire

// ---- design/gpib_status_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpib_status_core
    import gpib_resp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire stat_ctl_s i_ctl,
    input wire err_s i_err,
    input wire logic i_rsp_avail,
    input wire logic [15:0] i_meas_flags,
    output logic [7:0] o_esr,
    output logic [7:0] o_ese,
    output logic [7:0] o_sre,
    output logic [15:0] o_mce,
    output logic [7:0] o_stb,
    output logic o_srq
);

    typedef struct packed {
        logic [7:0] esr;
        logic [7:0] event_status_mask;
        logic [7:0] service_request_mask;
        logic [15:0] measurement_condition_mask;
        logic [7:0] stb;
        logic srq;
    } core_s;

    localparam core_s CORE_RST = '{ESR_RST, MASK_RST, MASK_RST, MCE_RST, 8'h00, 1'b0};

    core_s st_reg;
    core_s st_next;

    always_comb begin
        logic [7:0] sum;
        sum = 8'h00;
        st_next = st_reg;
        // Clear first so a same-cycle event survives
        if (i_ctl.esr_clr) begin
            st_next.esr = 8'h00; // R20
        end
        if (i_ctl.opc) begin
            st_next.esr[ESR_OPC] = 1'b1; // R10
        end
        if (i_err.query) begin
            st_next.esr[ESR_QRY] = 1'b1;
        end
        if (i_err.exec) begin
            st_next.esr[ESR_EXE] = 1'b1;
        end
        if (i_err.cmd) begin
            st_next.esr[ESR_CME] = 1'b1;
        end
        if (i_ctl.ese_wr) begin
            st_next.event_status_mask = i_ctl.arg[7:0]; // R7
        end
        if (i_ctl.sre_wr) begin
            st_next.service_request_mask = i_ctl.arg[7:0]; // R11
        end
        if (i_ctl.mce_wr) begin
            st_next.measurement_condition_mask = i_ctl.arg; // R18
        end
        sum[STB_MCB] = |(i_meas_flags & st_reg.measurement_condition_mask); // R13
        sum[STB_MAV] = i_rsp_avail; // R14
        sum[STB_ESB] = |(st_reg.esr & st_reg.event_status_mask); // R8
        sum[STB_MSS] = |(sum & st_reg.service_request_mask); // R15
        st_next.stb = sum;
        st_next.srq = sum[STB_MSS]; // R21
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_reg <= CORE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_esr = st_reg.esr;
    assign o_ese = st_reg.event_status_mask;
    assign o_sre = st_reg.service_request_mask;
    assign o_mce = st_reg.measurement_condition_mask;
    assign o_stb = st_reg.stb;
    assign o_srq = st_reg.srq;

endmodule : gpib_status_core
`default_nettype wire

// ---- dv/gpib_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpib_host_model
    import gpib_resp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_cmd_ready,
    input wire logic i_rsp_valid,
    input wire rsp_s i_rsp,
    output logic o_cmd_valid,
    output cmd_s o_cmd,
    output logic o_rsp_ready
);
    // ----------------------------------------
    // Controller side of the command port
    // ----------------------------------------
    rsp_s got[$];
    int stall = 0;
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd = '0;
        o_rsp_ready = 1'b0;
    end
    task automatic issue(input cmd_code_e c, input logic [15:0] a, input logic [3:0] ch, input logic g);
        int n;
        n = 0;
        @(negedge i_clk);
        o_cmd_valid = 1'b1;
        o_cmd = '{c, a, ch, g};
        while (!i_cmd_ready && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        @(negedge i_clk);
        o_cmd_valid = 1'b0;
        // Released lines carry no stale value
        o_cmd = cmd_s'(~o_cmd);
    endtask : issue
    task automatic read_all();
        int n;
        n = 0;
        got.delete();
        do begin
            while (!i_rsp_valid && n < 100) begin
                @(negedge i_clk);
                n++;
            end
            repeat (stall) @(negedge i_clk);
            got.push_back(i_rsp);
            o_rsp_ready = 1'b1;
            @(negedge i_clk);
            o_rsp_ready = 1'b0;
            n++;
        end while (!got[$].last && n < 100);
    endtask : read_all
endmodule : gpib_host_model
`default_nettype wire

// ---- dv/gpib_status_and_id_responder_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpib_resp_checker
    import gpib_resp_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic i_CMD_VALID,
    input wire cmd_s i_CMD,
    input wire logic o_CMD_READY,
    input wire logic o_CMD_REJECT,
    input wire logic o_RSP_VALID,
    input wire rsp_s o_RSP,
    input wire logic i_RSP_READY,
    input wire logic [15:0] i_MEAS_FLAGS,
    input wire logic [7:0] o_STATUS_BYTE,
    input wire logic o_SRQ
);
    // ----------------------------------------
    // Command, response and status relations
    // ----------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    logic tk;
    logic qry;
    assign tk = i_CMD_VALID && o_CMD_READY && i_CMD.gpib;
    assign qry = i_CMD.code inside {CMD_ESE_Q, CMD_SRE_Q, CMD_STB_Q, CMD_TST_Q, CMD_MCE_Q, CMD_ESR_Q};
    property p_reject;
        i_CMD_VALID && o_CMD_READY && !i_CMD.gpib && i_CMD.code inside {[CMD_WAIT:CMD_ESR_Q]}
            |=> o_CMD_REJECT && !o_RSP_VALID;
    endproperty
    a_reject: assert property (p_reject) else $error("status command off GPIB not refused");
    property p_wait;
        tk && i_CMD.code == CMD_WAIT |=> !o_CMD_REJECT && !o_RSP_VALID;
    endproperty
    a_wait: assert property (p_wait) else $error("wait command had an effect");
    property p_query;
        tk && qry |=> o_RSP_VALID && o_RSP.kind == FK_INT && o_RSP.last;
    endproperty
    a_query: assert property (p_query) else $error("query gave no integer answer");
    property p_tst;
        tk && i_CMD.code == CMD_TST_Q |=> o_RSP.data == TST_ANSWER;
    endproperty
    a_tst: assert property (p_tst) else $error("self-test answer not zero");
    property p_idn;
        i_CMD_VALID && o_CMD_READY && i_CMD.code == CMD_IDN_Q |=> o_RSP.kind == FK_MAKER && !o_RSP.last;
    endproperty
    a_idn: assert property (p_idn) else $error("identity answer does not open with maker");
    property p_hold;
        o_RSP_VALID && !i_RSP_READY |=> o_RSP_VALID && $stable(o_RSP) && !o_CMD_READY;
    endproperty
    a_hold: assert property (p_hold) else $error("response field dropped before read");
    property p_mav;
        o_RSP_VALID [*2] |-> o_STATUS_BYTE[STB_MAV];
    endproperty
    a_mav: assert property (p_mav) else $error("pending response not shown in status");
    property p_meas;
        i_MEAS_FLAGS == 16'h0000 [*3] |-> !o_STATUS_BYTE[STB_MCB];
    endproperty
    a_meas: assert property (p_meas) else $error("measurement bit set with no flags");
    property p_mss;
        o_SRQ == o_STATUS_BYTE[STB_MSS];
    endproperty
    a_mss: assert property (p_mss) else $error("summary bit and service request differ");
    property p_srq;
        o_SRQ |-> (o_STATUS_BYTE & 8'hBF) != 8'h00;
    endproperty
    a_srq: assert property (p_srq) else $error("service request with no status bit");
    c_srq: cover property (o_SRQ);
    c_reject: cover property (o_CMD_REJECT);
    c_chain: cover property (o_RSP_VALID && !o_RSP.last ##1 o_RSP_VALID);
endmodule : gpib_resp_checker
bind gpib_status_and_id_responder gpib_resp_checker u_chk (.I_CLK(I_CLK), .I_RESET(I_RESET),
    .i_CMD_VALID(i_CMD_VALID), .i_CMD(i_CMD), .o_CMD_READY(o_CMD_READY), .o_CMD_REJECT(o_CMD_REJECT),
    .o_RSP_VALID(o_RSP_VALID), .o_RSP(o_RSP), .i_RSP_READY(i_RSP_READY), .i_MEAS_FLAGS(i_MEAS_FLAGS),
    .o_STATUS_BYTE(o_STATUS_BYTE), .o_SRQ(o_SRQ));
`default_nettype wire

// ---- dv/gpib_status_and_id_responder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpib_status_and_id_responder_tb
    import gpib_resp_pkg::*;
;
    // ----------------------------------------
    // Bench
    // ----------------------------------------
    logic clk, rst, cmd_ready, reject, rsp_valid, rsp_ready, cmd_valid, srq, opt;
    cmd_s cmd;
    rsp_s rsp;
    logic [15:0] meas;
    chan_info_s [3:0] chan;
    err_s perr;
    logic [7:0] stb;
    logic [31:0] d;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    gpib_status_and_id_responder #(.NUM_CH(4), .FW_MAJOR(32'h00000003), .FW_MINOR(32'h00000002),
        .FW_BUILD(32'h00000007)) u_dut (.I_CLK(clk), .I_RESET(rst), .i_CMD_VALID(cmd_valid), .i_CMD(cmd),
        .o_CMD_READY(cmd_ready), .o_CMD_REJECT(reject), .o_RSP_VALID(rsp_valid), .o_RSP(rsp),
        .i_RSP_READY(rsp_ready), .i_MEAS_FLAGS(meas), .i_CHAN_INFO(chan), .i_OPTION_FITTED(opt),
        .i_PARSE_ERR(perr), .o_STATUS_BYTE(stb), .o_SRQ(srq));
    gpib_host_model u_host (.i_clk(clk), .i_cmd_ready(cmd_ready), .i_rsp_valid(rsp_valid), .i_rsp(rsp),
        .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_rsp_ready(rsp_ready));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task automatic ask(input cmd_code_e c);
        u_host.issue(c, 16'h0000, 4'h0, 1'b1);
        u_host.read_all();
        d = u_host.got[0].data;
    endtask : ask
    task automatic put(input cmd_code_e c, input logic [15:0] a);
        u_host.issue(c, a, 4'h0, 1'b1);
        repeat (3) @(negedge clk);
    endtask : put
    task automatic t_masks();
        cmd_code_e wr[3] = '{CMD_ESE, CMD_SRE, CMD_MCE};
        cmd_code_e rd[3] = '{CMD_ESE_Q, CMD_SRE_Q, CMD_MCE_Q};
        logic [15:0] v[3] = '{16'h00FF, 16'h00A5, 16'hFFFF};
        check("stb reset", 32'(stb), 32'h00000000);
        for (int i = 0; i < 3; i++) begin
            ask(rd[i]);
            check("mask reset", d, 32'h00000000);
            put(wr[i], v[i]);
            repeat (2) begin
                ask(rd[i]);
                check("mask", d, {16'h0000, v[i]});
            end
            put(wr[i], 16'h0000);
        end
    endtask : t_masks
    task automatic t_events();
        put(CMD_ESE, 16'h0001);
        put(CMD_OPC, 16'h0000);
        check("esb", 32'(stb[STB_ESB]), 32'h00000001);
        ask(CMD_ESR_Q);
        check("esr", d, 32'h00000001);
        repeat (3) @(negedge clk);
        check("esb clear", 32'(stb[STB_ESB]), 32'h00000000);
        ask(CMD_ESR_Q);
        check("esr clear", d, 32'h00000000);
        for (int i = 0; i < 3; i++) begin
            perr = err_s'(3'h4 >> i);
            @(negedge clk);
            perr = '0;
            ask(CMD_ESR_Q);
            check("esr err", d, 32'h00000008 << i);
        end
    endtask : t_events
    task automatic t_srq();
        put(CMD_SRE, 16'h0020);
        put(CMD_OPC, 16'h0000);
        check("srq", 32'(srq), 32'h00000001);
        check("mss", 32'(stb[STB_MSS]), 32'h00000001);
        ask(CMD_ESR_Q);
        repeat (3) @(negedge clk);
        check("srq off", 32'(srq), 32'h00000000);
        put(CMD_SRE, 16'h0000);
    endtask : t_srq
    task automatic t_meas();
        put(CMD_MCE, 16'h0004);
        meas = 16'h0004;
        repeat (3) @(negedge clk);
        check("mcb", 32'(stb[STB_MCB]), 32'h00000001);
        ask(CMD_STB_Q);
        check("stb query", 32'(d[STB_MCB]), 32'h00000001);
        meas = 16'h0008;
        repeat (3) @(negedge clk);
        check("mcb masked", 32'(stb[STB_MCB]), 32'h00000000);
        meas = 16'h0000;
    endtask : t_meas
    task automatic t_fixed();
        ask(CMD_TST_Q);
        check("tst", d, 32'h00000000);
        put(CMD_WAIT, 16'h0000);
        check("wait", 32'(rsp_valid), 32'h00000000);
        u_host.issue(CMD_ESE, 16'h003C, 4'h0, 1'b0);
        check("reject", 32'(reject), 32'h00000001);
        ask(CMD_ESE_Q);
        check("ese kept", d, 32'h00000001);
    endtask : t_fixed
    task automatic t_channel_info_query();
        logic [15:0] ty[3] = '{16'h4143, CHAN_ABSENT_CODE, CHAN_INVALID_CODE};
        logic [31:0] sn[3] = '{32'h00000011, 32'h00000000, 32'h00000005};
        u_host.stall = 2;
        for (int c = 0; c < 3; c++) begin
            u_host.issue(CMD_CHANNEL_INFO_QUERY_Q, 16'h0000, 4'(c), 1'b0);
            u_host.read_all();
            check("channel_info_query n", u_host.got.size(), 32'h00000002);
            check("channel_info_query type", 32'(u_host.got[0].data[15:0]), 32'(ty[c]));
            check("channel_info_query kind", 32'(u_host.got[1].kind), 32'(FK_INT));
            check("channel_info_query serial", u_host.got[1].data, sn[c]);
        end
        // Channel beyond the configured NUM_CH count: no answer, execution error
        u_host.issue(CMD_CHANNEL_INFO_QUERY_Q, 16'h0000, 4'h4, 1'b1);
        repeat (3) @(negedge clk);
        check("channel_info_query range", 32'(rsp_valid), 32'h00000000);
        ask(CMD_ESR_Q);
        check("channel_info_query range esr", d, 32'h00000010);
    endtask : t_channel_info_query
    task automatic t_id();
        field_kind_e k[6];
        logic [31:0] fw[3] = '{32'h00000003, 32'h00000002, 32'h00000007};
        for (int o = 0; o < 2; o++) begin
            opt = o[0];
            k = '{FK_MAKER, o ? FK_MODEL_OPT : FK_MODEL, FK_SERIAL, FK_INT, FK_INT, FK_INT};
            u_host.issue(CMD_IDN_Q, 16'h0000, 4'h0, 1'b0);
            u_host.read_all();
            check("idn n", u_host.got.size(), 32'h00000006);
            for (int i = 0; i < 6; i++) begin
                check("idn kind", 32'(u_host.got[i].kind), 32'(k[i]));
            end
            for (int i = 0; i < 3; i++) begin
                check("idn fw", u_host.got[3 + i].data, fw[i]);
            end
        end
        u_host.issue(CMD_NAME_Q, 16'h0000, 4'h0, 1'b0);
        u_host.read_all();
        check("name", 32'(u_host.got[0].kind), 32'(FK_NAME));
    endtask : t_id
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        rst = 1'b1;
        meas = 16'h0000;
        opt = 1'b0;
        perr = '0;
        chan = '{'{1'b1, 1'b1, 16'h4142, 32'h00000009}, '{1'b1, 1'b0, 16'h4142, 32'h00000005},
            '{1'b0, 1'b0, 16'h0000, 32'h00000000}, '{1'b1, 1'b1, 16'h4143, 32'h00000011}};
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_masks();
        t_events();
        t_srq();
        t_meas();
        t_fixed();
        t_channel_info_query();
        t_id();
        summarize();
    end
endmodule : gpib_status_and_id_responder_tb
`default_nettype wire

// ---- pkg/gpib_resp_pkg.sv ----
`default_nettype none
package gpib_resp_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ARG_W = 16;
    localparam int unsigned NFIELD = 6;

    // ----------------------------------------
    // Event status layout
    // ----------------------------------------
    localparam int unsigned ESR_OPC = 0;
    localparam int unsigned ESR_QRY = 3;
    localparam int unsigned ESR_EXE = 4;
    localparam int unsigned ESR_CME = 5;

    // ----------------------------------------
    // Status byte layout
    // ----------------------------------------
    localparam int unsigned STB_MCB = 0;
    localparam int unsigned STB_MAV = 4;
    localparam int unsigned STB_ESB = 5;
    localparam int unsigned STB_MSS = 6;

    // ----------------------------------------
    // Reset values and fixed answers
    // ----------------------------------------
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] ESR_RST = 8'h00;
    localparam logic [15:0] MCE_RST = 16'h0000;
    localparam logic [DATA_W-1:0] TST_ANSWER = 32'h00000000;
    localparam logic [15:0] CHAN_ABSENT_CODE = 16'h4E46;
    localparam logic [15:0] CHAN_INVALID_CODE = 16'h4E49;

    // ----------------------------------------
    // Commands and field kinds
    // ----------------------------------------
    typedef enum logic [3:0] {
        CMD_CHANNEL_INFO_QUERY_Q = 4'h0,
        CMD_NAME_Q = 4'h1,
        CMD_IDN_Q = 4'h2,
        CMD_WAIT = 4'h3,
        CMD_ESE = 4'h4,
        CMD_ESE_Q = 4'h5,
        CMD_OPC = 4'h6,
        CMD_SRE = 4'h7,
        CMD_SRE_Q = 4'h8,
        CMD_STB_Q = 4'h9,
        CMD_TST_Q = 4'hA,
        CMD_MCE = 4'hB,
        CMD_MCE_Q = 4'hC,
        CMD_ESR_Q = 4'hD
    } cmd_code_e;

    typedef enum logic [2:0] {
        FK_INT = 3'h0,
        FK_TYPE = 3'h1,
        FK_MAKER = 3'h2,
        FK_MODEL = 3'h3,
        FK_MODEL_OPT = 3'h4,
        FK_SERIAL = 3'h5,
        FK_NAME = 3'h6
    } field_kind_e;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        cmd_code_e code;
        logic [ARG_W-1:0] arg;
        logic [3:0] chan;
        logic gpib;
    } cmd_s;

    typedef struct packed {
        field_kind_e kind;
        logic [DATA_W-1:0] data;
        logic last;
    } rsp_s;

    typedef struct packed {
        logic fitted;
        logic valid;
        logic [15:0] type_code;
        logic [DATA_W-1:0] serial;
    } chan_info_s;

    typedef struct packed {
        logic query;
        logic exec;
        logic cmd;
    } err_s;

    typedef struct packed {
        logic ese_wr;
        logic sre_wr;
        logic mce_wr;
        logic opc;
        logic esr_clr;
        logic [ARG_W-1:0] arg;
    } stat_ctl_s;

endpackage : gpib_resp_pkg
`default_nettype wire
